// ---- rrg_defs.svh ----
// register offsets, field positions, reset values and timing figures of the reset generator
// assumes an 8-bit register port and a 100 ns system clock
`ifndef RRG_DEFS_SVH
`define RRG_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RRG_PRI_SEL_A_OFF 8'h29
`define RRG_PRI_SEL_B_OFF 8'h2A
`define RRG_PRI_SEL_C_OFF 8'h2B
`define RRG_SEC_SEL_A_OFF 8'h2C
`define RRG_SEC_SEL_B_OFF 8'h2D
`define RRG_CFG_OFF 8'h2E
`define RRG_STATUS_OFF 8'h40

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RRG_LEVEL_BIT 7
`define RRG_CODE_MSB 6
`define RRG_SEC_POL_BIT 7
`define RRG_PRI_POL_BIT 6
`define RRG_MERGE_BIT 5
`define RRG_HOLD_MSB 4
`define RRG_HOLD_LSB 2
`define RRG_WIDTH_MSB 1
`define RRG_WIDTH_LSB 0
`define RRG_REG_RESET 8'h00
`define RRG_KEY_LAST 7'h19

// ----------------------------------------
// timing figures
// ----------------------------------------
`define RRG_CLK_NS 100
`define RRG_HOLD_BASE_MS 1000
`define RRG_HOLD_STEP_MS 500
`define RRG_PW0_US 500
`define RRG_PW1_US 1000
`define RRG_PW2_US 2000
`define RRG_PW3_US 10000

`endif

// ---- rrg_pkg.sv ----
// types shared by the reset generator modules
// assumes nothing beyond a SystemVerilog compiler
package rrg_pkg;
	typedef logic [25:0] rrg_cnt_t;

	typedef struct packed {
		logic level;
		logic [6:0] code;
	} rrg_sel_s;

	typedef enum logic [1:0] {
		RRG_IDLE = 2'b00,
		RRG_HOLD = 2'b01,
		RRG_PULSE = 2'b10,
		RRG_WAIT = 2'b11
	} rrg_state_e;
endpackage

// ---- rrg_chan_if.sv ----
// one reset channel: match condition and timing in, pulse activity out
// assumes the top drives the ctl side and a pulse engine the gen side
`timescale 1ns/1ps
`default_nettype none
interface rrg_chan_if;
	logic cond;
	rrg_pkg::rrg_cnt_t hold_cyc;
	rrg_pkg::rrg_cnt_t width_cyc;
	logic active;

	modport gen (input cond, input hold_cyc, input width_cyc, output active);
	modport ctl (output cond, output hold_cyc, output width_cyc, input active);
endinterface
`default_nettype wire

// ---- rrg_match.sv ----
// one event selector compared against the live event state vector
// assumes event_level bit n is the present state of event code n
`timescale 1ns/1ps
`default_nettype none
module rrg_match (
	input wire logic [6:0] code,
	input wire logic level,
	input wire logic [6:0] key_last,
	input wire logic [127:0] event_level,
	output logic enabled,
	output logic hit
);
	logic is_key;
	logic state;

	assign enabled = (code != 7'h00);
	assign is_key = (code <= key_last);
	assign state = event_level[code];
	// key: only a held press counts, a release selection never matches
	// other sources: the level bit picks active or inactive
	assign hit = enabled && (is_key ? (level && state) : (state == level));
endmodule
`default_nettype wire

// ---- rrg_pulse.sv ----
// hold timer and pulse former for one reset output
// assumes hold and width counts are stable while a pulse is pending
`timescale 1ns/1ps
`default_nettype none
module rrg_pulse (
	input wire logic clk,
	input wire logic arst_n,
	rrg_chan_if.gen ch
);
	rrg_pkg::rrg_state_e state;
	rrg_pkg::rrg_cnt_t cnt;
	rrg_pkg::rrg_cnt_t cond_run;
	rrg_pkg::rrg_cnt_t act_len;

	assign ch.active = (state == rrg_pkg::RRG_PULSE);

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	// one pulse per assertion of the condition: rearm only after it drops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= rrg_pkg::RRG_IDLE;
			cnt <= '0;
		end else begin
			unique case (state)
				rrg_pkg::RRG_IDLE: begin
					cnt <= 26'h0000001;
					if (ch.cond) begin
						if (ch.hold_cyc <= 26'h0000001) begin
							state <= rrg_pkg::RRG_PULSE;
							cnt <= '0;
						end else begin
							state <= rrg_pkg::RRG_HOLD;
						end
					end
				end
				rrg_pkg::RRG_HOLD: begin
					if (!ch.cond) begin
						state <= rrg_pkg::RRG_IDLE;
					end else if (cnt >= ch.hold_cyc - 26'h0000001) begin
						state <= rrg_pkg::RRG_PULSE;
						cnt <= '0;
					end else begin
						cnt <= cnt + 26'h0000001;
					end
				end
				rrg_pkg::RRG_PULSE: begin
					if (cnt >= ch.width_cyc - 26'h0000001) begin
						state <= rrg_pkg::RRG_WAIT;
					end else begin
						cnt <= cnt + 26'h0000001;
					end
				end
				rrg_pkg::RRG_WAIT: begin
					if (!ch.cond) begin
						state <= rrg_pkg::RRG_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cond_run <= '0;
			act_len <= '0;
		end else begin
			cond_run <= !ch.cond ? '0 : ((&cond_run) ? cond_run : cond_run + 26'h0000001);
			act_len <= ch.active ? act_len + 26'h0000001 : '0;
		end
	end

	hold_time_met_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		$rose(ch.active) |-> (cond_run >= ch.hold_cyc) && $past(ch.cond))
		else $error("pulse started before the hold time elapsed");

	pulse_width_exact_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		$fell(ch.active) |-> act_len == $past(ch.width_cyc))
		else $error("pulse length differs from the selected width");
endmodule
`default_nettype wire

// ---- rrg_top.sv ----
// event combination reset generator: selectors, config, two reset outputs
// assumes synchronous inputs, a 10 MHz clock and a one-cycle strobe register port
//
// Overview of operation
// - primary output uses up to three selectors A, B, C, each with level bit
// - secondary output uses up to two selectors A, B, each with level bit
// - a selector whose code is zero takes no part in matching
// - output triggers only while all enabled selectors match at once
// - bit 7 of each selector register is its level qualifier
// - for a key code, level one makes a held press count
// - for a key code, level zero never matches; releases never cause reset
// - for inputs and logic outputs, level picks inactive or active state
// - shared hold time: immediate or 1.0 s to 4.0 s in 0.5 s steps
// - shared pulse width: 500 us, 1 ms, 2 ms or 10 ms
// - each output has its own polarity bit, zero low, one high
// - merge bit ORs external reset pin into primary output only
//
// The strobed register port is this design's own decision.
`include "rrg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rrg_top #(
	parameter int unsigned HOLD_BASE_CYC = (`RRG_HOLD_BASE_MS * 1000000) / `RRG_CLK_NS,
	parameter int unsigned HOLD_STEP_CYC = (`RRG_HOLD_STEP_MS * 1000000) / `RRG_CLK_NS,
	parameter int unsigned PW0_CYC = (`RRG_PW0_US * 1000 + `RRG_CLK_NS - 1) / `RRG_CLK_NS,
	parameter int unsigned PW1_CYC = (`RRG_PW1_US * 1000 + `RRG_CLK_NS - 1) / `RRG_CLK_NS,
	parameter int unsigned PW2_CYC = (`RRG_PW2_US * 1000 + `RRG_CLK_NS - 1) / `RRG_CLK_NS,
	parameter int unsigned PW3_CYC = (`RRG_PW3_US * 1000 + `RRG_CLK_NS - 1) / `RRG_CLK_NS,
	parameter logic [6:0] KEY_LAST = `RRG_KEY_LAST
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic [127:0] event_level,
	input wire logic ext_reset_n,
	output logic primary_reset_out,
	output logic secondary_reset_out
);
	localparam int NSEL = 5;
	localparam logic [7:0] SEL_OFF [NSEL] = '{`RRG_PRI_SEL_A_OFF, `RRG_PRI_SEL_B_OFF,
		`RRG_PRI_SEL_C_OFF, `RRG_SEC_SEL_A_OFF, `RRG_SEC_SEL_B_OFF};

	rrg_pkg::rrg_sel_s sel [NSEL];
	logic [7:0] cfg;
	logic [NSEL-1:0] sel_en;
	logic [NSEL-1:0] sel_hit;
	logic [NSEL-1:0] sel_ok;
	logic [1:0] chan_cond;
	logic [1:0] chan_active;
	logic [2:0] event_hold_time;
	logic [1:0] pulse_width;
	logic primary_out_polarity;
	logic secondary_out_polarity;
	logic ext_reset_merge_en;
	rrg_pkg::rrg_cnt_t hold_cyc;
	rrg_pkg::rrg_cnt_t width_cyc;
	logic primary_assert;
	logic secondary_assert;
	logic [7:0] next_rd_data;

	// ----------------------------------------
	// selectors
	// ----------------------------------------
	for (genvar i = 0; i < NSEL; i++) begin : g_sel
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				sel[i] <= `RRG_REG_RESET;
			end else if (wr_en && addr == SEL_OFF[i]) begin
				sel[i].level <= wr_data[`RRG_LEVEL_BIT];
				sel[i].code <= wr_data[`RRG_CODE_MSB:0];
			end
		end

		rrg_match u_match (
			.code(sel[i].code),
			.level(sel[i].level),
			.key_last(KEY_LAST),
			.event_level(event_level),
			.enabled(sel_en[i]),
			.hit(sel_hit[i])
		);
	end

	// unused selectors pass, but a channel with none enabled never fires
	assign sel_ok = sel_hit | ~sel_en;
	assign chan_cond[0] = (|sel_en[2:0]) && (&sel_ok[2:0]);
	assign chan_cond[1] = (|sel_en[4:3]) && (&sel_ok[4:3]);

	// ----------------------------------------
	// configuration
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= `RRG_REG_RESET;
		end else if (wr_en && addr == `RRG_CFG_OFF) begin
			cfg <= wr_data;
		end
	end

	assign secondary_out_polarity = cfg[`RRG_SEC_POL_BIT];
	assign primary_out_polarity = cfg[`RRG_PRI_POL_BIT];
	assign ext_reset_merge_en = cfg[`RRG_MERGE_BIT];
	assign event_hold_time = cfg[`RRG_HOLD_MSB:`RRG_HOLD_LSB];
	assign pulse_width = cfg[`RRG_WIDTH_MSB:`RRG_WIDTH_LSB];

	// ----------------------------------------
	// timing selection
	// ----------------------------------------
	always_comb begin
		hold_cyc = '0;
		if (event_hold_time != 3'h0) begin
			hold_cyc = 26'(HOLD_BASE_CYC + (32'(event_hold_time) - 32'd1) * HOLD_STEP_CYC);
		end
	end

	always_comb begin
		unique case (pulse_width)
			2'h0: width_cyc = 26'(PW0_CYC);
			2'h1: width_cyc = 26'(PW1_CYC);
			2'h2: width_cyc = 26'(PW2_CYC);
			2'h3: width_cyc = 26'(PW3_CYC);
		endcase
	end

	// ----------------------------------------
	// pulse engines
	// ----------------------------------------
	rrg_chan_if chan [2] ();

	for (genvar c = 0; c < 2; c++) begin : g_chan
		assign chan[c].cond = chan_cond[c];
		assign chan[c].hold_cyc = hold_cyc;
		assign chan[c].width_cyc = width_cyc;
		assign chan_active[c] = chan[c].active;

		rrg_pulse u_pulse (
			.clk(clk),
			.arst_n(arst_n),
			.ch(chan[c])
		);
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// the pin merge bypasses the hold timer so an external reset acts at once
	assign primary_assert = chan_active[0] || (ext_reset_merge_en && !ext_reset_n);
	assign secondary_assert = chan_active[1];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			primary_reset_out <= 1'b1;
		end else begin
			primary_reset_out <= primary_out_polarity ? primary_assert : !primary_assert;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			secondary_reset_out <= 1'b1;
		end else begin
			secondary_reset_out <= secondary_out_polarity ? secondary_assert : !secondary_assert;
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_comb begin
		next_rd_data = 8'h00;
		for (int i = 0; i < NSEL; i++) begin
			if (addr == SEL_OFF[i]) begin
				next_rd_data = sel[i];
			end
		end
		if (addr == `RRG_CFG_OFF) begin
			next_rd_data = cfg;
		end
		if (addr == `RRG_STATUS_OFF) begin
			next_rd_data = {4'h0, chan_active[1], chan_active[0], chan_cond[1], chan_cond[0]};
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= rd_en ? next_rd_data : 8'h00;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	zero_code_idle_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[0].code == 7'h00 && sel[1].code == 7'h00 && sel[2].code == 7'h00) |-> !chan_cond[0])
		else $error("primary condition raised with no selector in use");

	all_match_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		chan_cond[0] |-> (sel_hit[2:0] == sel_en[2:0]) && (sel_en[2:0] != 3'h0))
		else $error("primary condition raised while a selector misses");

	sec_match_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_en[4:3] != 2'h0 && (sel_hit[4:3] | ~sel_en[4:3]) == 2'h3) |-> chan_cond[1])
		else $error("secondary condition missed a full match");

	key_release_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[0].code != 7'h00 && sel[0].code <= KEY_LAST && !sel[0].level) |-> !sel_hit[0])
		else $error("key release selection matched");

	gen_level_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[3].code > KEY_LAST) |-> sel_hit[3] == (event_level[sel[3].code] == sel[3].level))
		else $error("input level selection mismatched");

	level_store_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_en && addr == `RRG_PRI_SEL_A_OFF) |=> sel[0].level == $past(wr_data[7]))
		else $error("level bit not taken from bit 7");

	pri_polarity_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(chan_active[0] && $stable(cfg))
			|=> primary_reset_out == $past(primary_out_polarity))
		else $error("primary output at wrong level during pulse");

	merge_pin_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(ext_reset_merge_en && !ext_reset_n && !chan_active[1] && $stable(cfg))
			|=> primary_reset_out == $past(primary_out_polarity)
			&& secondary_reset_out == !$past(secondary_out_polarity))
		else $error("pin merge reached the wrong output");

	// ----------------------------------------
	// condition, timing, output and register checks
	// ----------------------------------------
	// consequents take the polarity of the launching edge, so a config write mid-pulse is legal
	sec_zero_idle_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[3].code == 7'h00 && sel[4].code == 7'h00) |-> !chan_cond[1])
		else $error("secondary condition raised with no selector in use");

	pri_full_match_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_en[2:0] != 3'h0 && (sel_hit[2:0] | ~sel_en[2:0]) == 3'h7) |-> chan_cond[0])
		else $error("primary condition missed a full match");

	sec_all_match_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		chan_cond[1] |-> (sel_hit[4:3] == sel_en[4:3]) && (sel_en[4:3] != 2'h0))
		else $error("secondary condition raised while a selector misses");

	sec_fire_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		$rose(chan_active[1]) |-> $past(chan_cond[1]))
		else $error("secondary pulse started without its condition");

	key_press_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[0].code != 7'h00 && sel[0].code <= KEY_LAST && sel[0].level)
			|-> sel_hit[0] == event_level[sel[0].code])
		else $error("held key press not matched");

	sec_key_release_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[3].code != 7'h00 && sel[3].code <= KEY_LAST && !sel[3].level) |-> !sel_hit[3])
		else $error("secondary key release selection matched");

	pri_gen_level_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel[0].code > KEY_LAST) |-> sel_hit[0] == (event_level[sel[0].code] == sel[0].level))
		else $error("primary input level selection mismatched");

	sel_store_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_en && addr == `RRG_SEC_SEL_B_OFF) |=> sel[4] == $past(wr_data))
		else $error("selector write not stored");

	cfg_store_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_en && addr == `RRG_CFG_OFF) |=> cfg == $past(wr_data))
		else $error("config write not stored");

	sec_polarity_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		chan_active[1] |=> secondary_reset_out == $past(secondary_out_polarity))
		else $error("secondary output at wrong level during pulse");

	pri_idle_level_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		!primary_assert |=> primary_reset_out == !$past(primary_out_polarity))
		else $error("primary output not at idle level");

	sec_idle_level_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		!chan_active[1] |=> secondary_reset_out == !$past(secondary_out_polarity))
		else $error("secondary output not at idle level");

	merge_off_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!ext_reset_merge_en && !chan_active[0])
			|=> primary_reset_out == !$past(primary_out_polarity))
		else $error("pin reached the primary output with merge off");

	merge_on_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(ext_reset_merge_en && !ext_reset_n) |=> primary_reset_out == $past(primary_out_polarity))
		else $error("pin did not reach the primary output with merge on");

	hold_zero_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(event_hold_time == 3'h0) |-> hold_cyc == 26'h0000000)
		else $error("immediate hold code gives a nonzero count");

	hold_min_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(event_hold_time == 3'h1) |-> hold_cyc == 26'(HOLD_BASE_CYC))
		else $error("shortest hold count wrong");

	hold_max_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(event_hold_time == 3'h7) |-> hold_cyc == 26'(HOLD_BASE_CYC + 6 * HOLD_STEP_CYC))
		else $error("longest hold count wrong");

	width_short_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(pulse_width == 2'h0) |-> width_cyc == 26'(PW0_CYC))
		else $error("shortest width count wrong");

	width_long_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(pulse_width == 2'h3) |-> width_cyc == 26'(PW3_CYC))
		else $error("longest width count wrong");

	read_idle_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		!rd_en |=> rd_data == 8'h00)
		else $error("read data outside the read cycle");

	read_cfg_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_en && addr == `RRG_CFG_OFF) |=> rd_data == $past(cfg))
		else $error("config read back wrong");

	read_status_a: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd_en && addr == `RRG_STATUS_OFF)
			|=> rd_data == {4'h0, $past(chan_active), $past(chan_cond)})
		else $error("status read back wrong");
endmodule
`default_nettype wire

// ---- rrg_sink.sv ----
// far-side receiver of one reset output: counts pulses, keeps the last width
// assumes the output is synchronous to clk and pol gives its asserted level
`timescale 1ns/1ps
`default_nettype none
module rrg_sink (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pol,
	input wire logic rst_in,
	output int n_pulse,
	output int last_w
);
	int run;
	// a polarity flip while idle shows as a one-cycle pulse; callers take deltas after settling
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run <= 0;
			n_pulse <= 0;
			last_w <= 0;
		end else if (rst_in === pol) begin
			run <= run + 1;
		end else if (run != 0) begin
			n_pulse <= n_pulse + 1;
			last_w <= run;
			run <= 0;
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench of the reset generator with shortened hold counts and shortened widths for codes 0, 2 and 3
// assumes rrg_top, rrg_sink and the shared defines are compiled before it
`include "rrg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {logic [39:0] sel; logic [63:0] ev; logic [1:0] fire;} rrg_row_s;
	logic clk, arst_n, wr_en, rd_en, ext_reset_n, primary_reset_out, secondary_reset_out;
	logic [7:0] addr, wr_data, rd_data, cfg;
	logic [127:0] event_level;
	int failures, n_checks, pn, pw, sn, sw, pa, sa, hc;
	int pwc [4] = '{3, `RRG_PW1_US * 1000 / `RRG_CLK_NS, 5, 6};
	rrg_row_s rows [6] = '{
		'{40'h8500000000, 64'h20, 2'b10},
		'{40'h0500000000, 64'h20, 2'b00},
		'{40'hA021000000, 64'h100000000, 2'b10},
		'{40'hA021000000, 64'h300000000, 2'b00},
		'{40'hA0A1A20000, 64'h300000000, 2'b00},
		'{40'h000000A0A1, 64'h300000000, 2'b01}};

	// width code 1 keeps its real length so the default width count is exercised
	rrg_top #(.HOLD_BASE_CYC(20), .HOLD_STEP_CYC(10), .PW0_CYC(3),
		.PW2_CYC(5), .PW3_CYC(6)) u_dut (.clk(clk),
		.arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .event_level(event_level), .ext_reset_n(ext_reset_n),
		.primary_reset_out(primary_reset_out), .secondary_reset_out(secondary_reset_out));
	rrg_sink u_psink (.clk(clk), .arst_n(arst_n), .pol(cfg[6]), .rst_in(primary_reset_out),
		.n_pulse(pn), .last_w(pw));
	rrg_sink u_ssink (.clk(clk), .arst_n(arst_n), .pol(cfg[7]), .rst_in(secondary_reset_out),
		.n_pulse(sn), .last_w(sw));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t byte got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			failures++;
			$display("[ERR] %0t count got %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		if (a == `RRG_CFG_OFF) cfg <= d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chk_b(rd_data, exp);
	endtask
	// events stand for cyc cycles, then drop for 12 cycles, long enough for the shortened pulses to end
	task automatic fire(input logic [63:0] ev, input int cyc);
		@(posedge clk);
		event_level <= {64'h0, ev};
		repeat (cyc) @(posedge clk);
		event_level <= '0;
		repeat (12) @(posedge clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		wrap_up();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{arst_n, wr_en, rd_en, addr, wr_data, cfg, event_level} = '0;
		ext_reset_n = 1'b1;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk_b({7'h0, primary_reset_out}, 8'h01);
		for (int i = 0; i < 6; i++) rd(8'(8'h29 + i), `RRG_REG_RESET);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(8'(8'h29 + i), 8'(8'hD0 + i));
			rd(8'(8'h29 + i), 8'(8'hD0 + i));
		end
		foreach (rows[i]) begin
			for (int j = 0; j < 5; j++) wr(8'(8'h29 + j), rows[i].sel[39 - 8 * j -: 8]);
			pa = pn;
			sa = sn;
			fire(rows[i].ev, 4);
			chk_n(pn - pa, int'(rows[i].fire[1]));
			chk_n(sn - sa, int'(rows[i].fire[0]));
		end
		wr(`RRG_SEC_SEL_B_OFF, 8'h00);
		wr(`RRG_SEC_SEL_A_OFF, 8'h00);
		wr(`RRG_PRI_SEL_A_OFF, 8'h85);
		for (int w = 0; w < 4; w++) begin
			wr(`RRG_CFG_OFF, 8'(w));
			fire(64'h20, 4);
			repeat (pwc[w]) @(posedge clk);
			chk_n(pw, pwc[w]);
		end
		for (int h = 1; h < 8; h += 6) begin
			wr(`RRG_CFG_OFF, 8'(h << 2));
			hc = 20 + (h - 1) * 10;
			pa = pn;
			fire(64'h20, hc - 5);
			chk_n(pn - pa, 0);
			fire(64'h20, hc + 5);
			chk_n(pn - pa, 1);
		end
		wr(`RRG_CFG_OFF, 8'hC0);
		wr(`RRG_SEC_SEL_A_OFF, 8'h85);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_b({6'h0, secondary_reset_out, primary_reset_out}, 8'h00);
		pa = pn;
		sa = sn;
		fire(64'h20, 4);
		chk_n(pn - pa + sn - sa, 2);
		chk_n(sw, 3);
		wr(`RRG_CFG_OFF, 8'h20);
		ext_reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_b({6'h0, secondary_reset_out, primary_reset_out}, 8'h02);
		ext_reset_n <= 1'b1;
		wr(`RRG_CFG_OFF, 8'h00);
		ext_reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_b({7'h0, primary_reset_out}, 8'h01);
		ext_reset_n <= 1'b1;
		wr(`RRG_CFG_OFF, 8'h03);
		event_level <= 128'h20;
		rd(`RRG_STATUS_OFF, 8'h0F);
		event_level <= '0;
		repeat (12) @(posedge clk);
		wr(`RRG_CFG_OFF, 8'h1C);
		event_level <= 128'h20;
		rd(`RRG_STATUS_OFF, 8'h03);
		event_level <= '0;
		rd(`RRG_STATUS_OFF, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
